/* lcc_pkg.sv */
// Constants and types shared by both ends of the local config control link
package lcc_pkg;

  // Register window and decode
  localparam logic [7:0]  LCC_OFFSET     = 8'h00;
  localparam logic [1:0]  BAR_IO         = 2'h2;
  localparam logic [1:0]  BAR_MEM        = 2'h3;

  // Access sizes carried on the link
  localparam logic [1:0]  SZ_BYTE        = 2'h0;
  localparam logic [1:0]  SZ_HALF        = 2'h1;
  localparam logic [1:0]  SZ_WORD        = 2'h2;

  // Field positions of the register
  localparam int          BIT_MODE_LO    = 0;
  localparam int          BIT_CLK_EN     = 2;
  localparam int          BIT_LANE_LO    = 3;
  localparam int          BIT_FILT_LO    = 5;
  localparam int          BIT_PME_EN     = 7;
  localparam int          BIT_EEPROM_SERIAL_CLOCK_PIN      = 24;
  localparam int          BIT_EEPROM_SELECT_PIN      = 25;
  localparam int          BIT_EEPROM_WRITE_DATA_PIN      = 26;
  localparam int          BIT_EEPROM_READ_DATA_PIN      = 27;
  localparam int          BIT_EE_VALID   = 28;
  localparam int          BIT_RELOAD     = 29;

  // Values after reset and the write-data reserved-bit mask
  localparam logic [5:0]  LOAD_FIELDS_RST = 6'h00;
  localparam logic [31:0] WORD_RST        = 32'h0000_0000;
  localparam logic [31:0] RSVD_ZERO_MASK  = 32'hff00_00ff;

  // Strap and filter encodings
  localparam logic [1:0]  MODE_LOCAL_BUS  = 2'h0;
  localparam logic [1:0]  MODE_PAR_PORT   = 2'h1;
  localparam logic [1:0]  FILT_OFF        = 2'h0;

  // Power-down filter times
  localparam longint unsigned CLK_HZ       = 20_000_000;
  localparam longint unsigned PD_SHORT_S   = 129;
  localparam longint unsigned PD_LONG_S    = 518;
  localparam int              PD_CNT_W     = 34;
  localparam logic [PD_CNT_W-1:0] PD_SHORT_CYC_DEF = PD_CNT_W'(PD_SHORT_S * CLK_HZ);
  localparam logic [PD_CNT_W-1:0] PD_LONG_CYC_DEF  = PD_CNT_W'(PD_LONG_S * CLK_HZ);

  // Controller APB register offsets
  localparam logic [7:0]  HR_CMD         = 8'h00;
  localparam logic [7:0]  HR_WDATA       = 8'h04;
  localparam logic [7:0]  HR_RDATA       = 8'h08;
  localparam logic [7:0]  HR_STATUS      = 8'h0c;
  localparam logic [7:0]  HR_IRQ_STAT    = 8'h10;
  localparam logic [7:0]  HR_IRQ_MASK    = 8'h14;

  // Controller command field positions
  localparam int          CMD_GO         = 0;
  localparam int          CMD_WR         = 1;
  localparam int          CMD_SIZE_LO    = 2;
  localparam int          CMD_BAR_LO     = 4;
  localparam int          CMD_FUNC       = 6;
  localparam int          CMD_OFF_LO     = 8;

  // Controller interrupt bits
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_ERR        = 1;

  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_WAIT = 1'b1
  } lcc_host_state_t;

endpackage

/* lcc_if.sv */
// Register access link between host controller and local config register
`timescale 1ns/1ns
interface lcc_if;
  logic        req;
  logic        wr;
  logic        func;
  logic [1:0]  bar;
  logic [7:0]  offset;
  logic [1:0]  size;
  logic [31:0] wdata;
  logic        ack;
  logic        err;
  logic [31:0] rdata;

  modport dev  (input req, wr, func, bar, offset, size, wdata, output ack, err, rdata);
  modport host (output req, wr, func, bar, offset, size, wdata, input ack, err, rdata);
endinterface

/* lcc_device.sv */
// Local configuration and control register, device end of the link
//
// What this block does
// - I/O bytes only; memory also 16/32-bit
// - Multi-byte memory access reverses byte order
// - Decoded in third/fourth BAR, both functions
// - Bits 1:0 return live strap pins
// - Bit 2 gates buffered serial clock output
// - Bits 4:3 pick 8-bit peripheral lane
// - Bits 6:5 pick power-down filter time
// - Interrupt if request outlasts filter time
// - Bit 7 lets pin two set PME
// - Bits 23:8 read zero, written zero
// - Bit 24 drives EEPROM clock pin
// - Bit 25 drives EEPROM select pin
// - Bit 26 drives EEPROM write data
// - Bit 27 returns EEPROM read data
// - Bit 28 shows valid EEPROM program
// - Bit 29 reloads config, self clears
// - Strap 00 local bus, 01 parallel
`timescale 1ns/1ns
module lcc_device #(
  parameter logic [lcc_pkg::PD_CNT_W-1:0] PD_SHORT_CYC = lcc_pkg::PD_SHORT_CYC_DEF,
  parameter logic [lcc_pkg::PD_CNT_W-1:0] PD_LONG_CYC  = lcc_pkg::PD_LONG_CYC_DEF
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  lcc_if.dev              link,
  input  wire logic [1:0] mode_strap_in,
  output logic            fn1_local_bus_sel_out,
  output logic            fn1_parallel_port_sel_out,
  input  wire logic       uart_clk_in,
  output logic            uart_clk_out,
  output logic [1:0]      byte_lane_sel_out,
  input  wire logic       fn0_pd_request_in,
  output logic            pd_irq_out,
  input  wire logic       multipurpose_pin_two_in,
  output logic            fn1_pme_status_set_out,
  output logic            eeprom_serial_clock_pin_out,
  output logic            eeprom_select_pin_out,
  output logic            eeprom_write_data_pin_out,
  input  wire logic       eeprom_read_data_pin_in,
  input  wire logic       eeprom_valid_in,
  output logic            reload_request_out,
  input  wire logic       load_done_in,
  input  wire logic [5:0] load_fields_in
);
  import lcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic                clk_en;
  logic [1:0]          lane_sel;
  logic [1:0]          filt_sel;
  logic                pme_en;
  logic                eeprom_serial_clock_pin;
  logic                eeprom_select_pin;
  logic                eeprom_write_data_pin;
  logic                reload;
  logic                ack_q;
  logic                err_q;
  logic [31:0]         rdata_q;
  logic [PD_CNT_W-1:0] pd_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  wire        take     = link.req && !ack_q;            // One take per request
  wire        io_acc   = (link.bar == BAR_IO);
  wire        mem_acc  = (link.bar == BAR_MEM);
  wire        size_ok  = (link.size == SZ_BYTE) || (link.size == SZ_HALF) ||
                         (link.size == SZ_WORD);
  wire        io_multi = io_acc && (link.size != SZ_BYTE);
  wire        refused  = !(io_acc || mem_acc) || !size_ok || io_multi;
  wire        hit      = (link.offset[7:2] == LCC_OFFSET[7:2]);
  wire        multi    = mem_acc && (link.size != SZ_BYTE);
  wire        wr_en    = take && link.wr && !refused && hit;

  // Host byte lanes touched by the access
  wire [3:0]  be_byte  = 4'h1 << link.offset[1:0];
  wire [3:0]  be_half  = link.offset[1] ? 4'hc : 4'h3;
  wire [3:0]  host_be  = (link.size == SZ_BYTE) ? be_byte :
                         (link.size == SZ_HALF) ? be_half : 4'hf;

  // Lane reversal for multi-byte memory accesses
  wire [3:0]  be_reg   = multi ? {host_be[0], host_be[1], host_be[2], host_be[3]}
                               : host_be;
  wire [31:0] wd       = link.wdata;
  wire [31:0] wd_reg   = multi ? {wd[7:0], wd[15:8], wd[23:16], wd[31:24]}
                               : wd;

  ////////////////////////////////////////////////////////////////////////////
  // Read view

  // Write-only bits and reserved bits read as zero
  wire [31:0] reg_view;
  assign reg_view[1:0]   = mode_strap_in;
  assign reg_view[2]     = clk_en;
  assign reg_view[4:3]   = lane_sel;
  assign reg_view[6:5]   = filt_sel;
  assign reg_view[7]     = pme_en;
  assign reg_view[23:8]  = 16'h0000;
  assign reg_view[26:24] = 3'h0;                       // Write-only EEPROM drive bits
  assign reg_view[27]    = eeprom_read_data_pin_in;
  assign reg_view[28]    = eeprom_valid_in;
  assign reg_view[29]    = 1'b0;
  assign reg_view[31:30] = 2'h0;

  wire [31:0] rd_host  = multi ? {reg_view[7:0], reg_view[15:8],
                                  reg_view[23:16], reg_view[31:24]}
                               : reg_view;
  wire [31:0] rd_next  = (refused || !hit || link.wr) ? WORD_RST : rd_host;

  ////////////////////////////////////////////////////////////////////////////
  // Link answer, one cycle after the take

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= WORD_RST;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q   <= refused;
        rdata_q <= rd_next;
      end
    end
  end

  assign link.ack   = ack_q;
  assign link.err   = err_q;
  assign link.rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields; a bus write in the load cycle overrides the load

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      {pme_en, filt_sel, lane_sel, clk_en} <= LOAD_FIELDS_RST;
    end else begin
      if (load_done_in) begin
        {pme_en, filt_sel, lane_sel, clk_en} <= load_fields_in;
      end
      if (wr_en && be_reg[0]) begin
        clk_en   <= wd_reg[BIT_CLK_EN];
        lane_sel <= wd_reg[BIT_LANE_LO +: 2];
        filt_sel <= wd_reg[BIT_FILT_LO +: 2];
        pme_en   <= wd_reg[BIT_PME_EN];
      end
    end
  end

  // EEPROM pin drive bits
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      eeprom_serial_clock_pin <= 1'b0;
      eeprom_select_pin <= 1'b0;
      eeprom_write_data_pin <= 1'b0;
    end else if (wr_en && be_reg[3]) begin
      eeprom_serial_clock_pin <= wd_reg[BIT_EEPROM_SERIAL_CLOCK_PIN];
      eeprom_select_pin <= wd_reg[BIT_EEPROM_SELECT_PIN];
      eeprom_write_data_pin <= wd_reg[BIT_EEPROM_WRITE_DATA_PIN];
    end
  end

  // Reload request; a new start beats the finishing load
  wire reload_set = wr_en && be_reg[3] && wd_reg[BIT_RELOAD];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      reload <= 1'b0;
    end else if (reload_set) begin
      reload <= 1'b1;
    end else if (load_done_in) begin
      reload <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down filter

  wire                pd_armed = fn0_pd_request_in && filt_sel[1];
  wire [PD_CNT_W-1:0] pd_limit = filt_sel[0] ? PD_LONG_CYC : PD_SHORT_CYC;
  wire                pd_full  = (pd_cnt >= pd_limit);

  // Counter restarts whenever the request drops
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pd_cnt <= '0;
    end else if (!pd_armed) begin
      pd_cnt <= '0;
    end else if (!pd_full) begin
      pd_cnt <= pd_cnt + PD_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered pin outputs

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      uart_clk_out              <= 1'b0;
      pd_irq_out                <= 1'b0;
      fn1_pme_status_set_out    <= 1'b0;
      fn1_local_bus_sel_out     <= 1'b0;
      fn1_parallel_port_sel_out <= 1'b0;
    end else begin
      uart_clk_out              <= uart_clk_in && clk_en;
      pd_irq_out                <= pd_armed && pd_full;
      fn1_pme_status_set_out    <= pme_en && multipurpose_pin_two_in;
      fn1_local_bus_sel_out     <= (mode_strap_in == MODE_LOCAL_BUS);
      fn1_parallel_port_sel_out <= (mode_strap_in == MODE_PAR_PORT);
    end
  end

  assign byte_lane_sel_out           = lane_sel;
  assign eeprom_serial_clock_pin_out = eeprom_serial_clock_pin;
  assign eeprom_select_pin_out       = eeprom_select_pin;
  assign eeprom_write_data_pin_out   = eeprom_write_data_pin;
  assign reload_request_out          = reload;

endmodule

/* lcc_host.sv */
// Host controller: APB registers that issue accesses over the link
`timescale 1ns/1ns
module lcc_host (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             irq_out,
  lcc_if.host              link
);
  import lcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  lcc_host_state_t state;
  logic            cmd_wr;
  logic [1:0]      cmd_size;
  logic [1:0]      cmd_bar;
  logic            cmd_func;
  logic [7:0]      cmd_off;
  logic [31:0]     wdata_r;
  logic [31:0]     rdata_r;
  logic            last_err;
  logic [1:0]      irq_stat;
  logic [1:0]      irq_mask;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  wire setup     = psel_in && !penable_in;
  wire access    = psel_in && penable_in;
  wire wr_acc    = access && pwrite_in;
  wire sel_cmd   = (paddr_in == HR_CMD);
  wire sel_wdata = (paddr_in == HR_WDATA);
  wire sel_rdata = (paddr_in == HR_RDATA);
  wire sel_stat  = (paddr_in == HR_STATUS);
  wire sel_istat = (paddr_in == HR_IRQ_STAT);
  wire sel_imask = (paddr_in == HR_IRQ_MASK);
  wire mapped    = sel_cmd || sel_wdata || sel_rdata || sel_stat || sel_istat || sel_imask;
  wire idle      = (state == HS_IDLE);
  wire start     = wr_acc && sel_cmd && idle && pwdata_in[CMD_GO];
  wire done      = (state == HS_WAIT) && link.ack;

  wire [31:0] cmd_view = {16'h0000, cmd_off, 1'b0, cmd_func, cmd_bar, cmd_size, cmd_wr, 1'b0};
  wire [31:0] rd_mux   = sel_cmd   ? cmd_view :
                         sel_wdata ? wdata_r :
                         sel_rdata ? rdata_r :
                         sel_stat  ? {30'h0, last_err, !idle} :
                         sel_istat ? {30'h0, irq_stat} :
                         sel_imask ? {30'h0, irq_mask} : WORD_RST;

  // Zero wait states; read data captured during setup
  assign pready_out  = 1'b1;
  assign pslverr_out = access && !mapped;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      prdata_out <= WORD_RST;
    end else if (setup) begin
      prdata_out <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command and write data; held steady while an access is out

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      {cmd_off, cmd_func, cmd_bar, cmd_size, cmd_wr} <= 14'h0000;
      wdata_r <= WORD_RST;
    end else if (idle) begin
      if (wr_acc && sel_cmd) begin
        cmd_wr   <= pwdata_in[CMD_WR];
        cmd_size <= pwdata_in[CMD_SIZE_LO +: 2];
        cmd_bar  <= pwdata_in[CMD_BAR_LO +: 2];
        cmd_func <= pwdata_in[CMD_FUNC];
        cmd_off  <= pwdata_in[CMD_OFF_LO +: 8];
      end
      if (wr_acc && sel_wdata) begin
        wdata_r <= pwdata_in & RSVD_ZERO_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state    <= HS_IDLE;
      rdata_r  <= WORD_RST;
      last_err <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          if (start) begin
            state <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (link.ack) begin
            state    <= HS_IDLE;
            rdata_r  <= link.rdata;
            last_err <= link.err;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.req    = (state == HS_WAIT);
  assign link.wr     = cmd_wr;
  assign link.size   = cmd_size;
  assign link.bar    = cmd_bar;
  assign link.func   = cmd_func;
  assign link.offset = cmd_off;
  assign link.wdata  = wdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts; a new event beats a same-cycle clear

  wire [1:0] irq_set = {done && link.err, done};
  wire [1:0] irq_clr = (wr_acc && sel_istat) ? pwdata_in[1:0] : 2'h0;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_stat <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;
      if (wr_acc && sel_imask) begin
        irq_mask <= pwdata_in[1:0];
      end
    end
  end

  assign irq_out = |(irq_stat & irq_mask);

endmodule

/* lcc_asserts.sv */
// Checker on the link between the host controller and the register end
`timescale 1ns/1ns
module lcc_asserts
  import lcc_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic        func,
  input  wire logic [1:0]  bar,
  input  wire logic [7:0]  offset,
  input  wire logic [1:0]  size,
  input  wire logic [31:0] wdata,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [31:0] rdata
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Request taken at this edge
  wire take = req && !ack;

  ////////////////////////////////////////////////////////////////////////////
  // Handshake timing
  ack_after_take_a: assert property (take |=> ack)
    else $error("no answer one cycle after a request");
  ack_single_a: assert property (ack |=> !ack)
    else $error("answer held longer than one cycle");
  req_held_a: assert property (take |=> req && $stable({wr, bar, offset, size, wdata}))
    else $error("request changed before its answer");
  answer_hold_a: assert property (!ack |-> $stable(rdata) && $stable(err))
    else $error("read data or error changed without an answer");

  ////////////////////////////////////////////////////////////////////////////
  // Decode and refusals
  io_byte_only_a: assert property (take && bar == BAR_IO && size != SZ_BYTE |=> err)
    else $error("wide access through the io window accepted");
  mem_sizes_a: assert property (take && bar == BAR_MEM && size != 2'h3 |=> !err)
    else $error("legal memory access refused");
  bar_decode_a: assert property (take && bar != BAR_IO && bar != BAR_MEM |=> err)
    else $error("access outside both windows accepted");
  other_offset_a: assert property (ack && !err && !wr && offset[7:2] != 6'h0 |-> rdata == 32'h0)
    else $error("unused offset read non-zero");
  word_zeros_a: assert property (ack && !err && !wr && bar == BAR_MEM && size == SZ_WORD
    |-> (rdata & 32'h00ff_ffe7) == 32'h0)
    else $error("reserved or write-only bits read non-zero");

  // Main scenarios reached
  cover property (take && wr && bar == BAR_MEM);
  cover property (ack && err);
  cover property (take && bar == BAR_IO && size == SZ_BYTE);
endmodule

/* local_config_control_register_test.sv */
// Testbench driving the host controller and register end through apb
`timescale 1ns/1ns
module local_config_control_register_test;
  import lcc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n, psel, penable, pwrite, uclk, pd_req, mp2, eeprom_read_data_pin, ee_ok, ld_done, fn, lerr;
  logic        pready, pslverr, irq, lb_sel, pp_sel, uclk_o, pd_irq, pme, eeprom_serial_clock_pin, eeprom_select_pin, eeprom_write_data_pin, reload;
  logic [1:0]  strap, lane;
  logic [5:0]  ld_f;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  bad [4] = '{{BAR_IO, SZ_HALF}, {BAR_IO, SZ_WORD}, {2'h0, SZ_BYTE}, {BAR_MEM, 2'h3}};
  logic [7:0]  pdb [4] = '{8'h40, 8'h60, 8'h00, 8'h20};
  int          pdlo [4] = '{20, 50, 80, 80};
  int          pdhi [4] = '{25, 55, 80, 80};
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;

  lcc_if link_if ();
  lcc_device #(.PD_SHORT_CYC(34'd20), .PD_LONG_CYC(34'd50)) lcc_device_inst (
    .clk_sys_in(clk), .rst_n_in(rst_n), .link(link_if), .mode_strap_in(strap),
    .fn1_local_bus_sel_out(lb_sel), .fn1_parallel_port_sel_out(pp_sel), .uart_clk_in(uclk),
    .uart_clk_out(uclk_o), .byte_lane_sel_out(lane), .fn0_pd_request_in(pd_req),
    .pd_irq_out(pd_irq), .multipurpose_pin_two_in(mp2), .fn1_pme_status_set_out(pme),
    .eeprom_serial_clock_pin_out(eeprom_serial_clock_pin), .eeprom_select_pin_out(eeprom_select_pin),
    .eeprom_write_data_pin_out(eeprom_write_data_pin), .eeprom_read_data_pin_in(eeprom_read_data_pin),
    .eeprom_valid_in(ee_ok), .reload_request_out(reload), .load_done_in(ld_done),
    .load_fields_in(ld_f));
  lcc_host lcc_host_inst (
    .clk_sys_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq), .link(link_if));
  lcc_asserts lcc_asserts_inst (
    .clk_sys_in(clk), .rst_n_in(rst_n), .req(link_if.req), .wr(link_if.wr),
    .func(link_if.func), .bar(link_if.bar), .offset(link_if.offset), .size(link_if.size),
    .wdata(link_if.wdata), .ack(link_if.ack), .err(link_if.err), .rdata(link_if.rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // Verdict and end of run
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Compare one result
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One apb transfer; read data and error left in rd and lerr
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register access through the controller, alternating functions
  task lnk(input logic w, input logic [1:0] sz, input logic [1:0] b, input logic [7:0] off,
           input logic [31:0] d);
    logic e;
    fn = ~fn;
    apb(1'b1, HR_WDATA, d);
    apb(1'b1, HR_CMD, {16'h0, off, 1'b0, fn, b, sz, w, 1'b1});
    do apb(1'b0, HR_STATUS, 32'h0); while (rd[0] !== 1'b0);
    e = rd[1];
    apb(1'b0, HR_RDATA, 32'h0);
    lerr = e;                    // Link error, not the data read's bus error
  endtask

  // Host lane order of a register word
  function automatic logic [31:0] swap(input logic [31:0] r);
    return {r[7:0], r[15:8], r[23:16], r[31:24]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, psel, penable, pwrite, uclk, pd_req, mp2, ld_done, fn, paddr, pwdata, ld_f} = '0;
    {strap, eeprom_read_data_pin, ee_ok} = 4'b0111;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk({uclk_o, lane, eeprom_serial_clock_pin, eeprom_select_pin, eeprom_write_data_pin, reload, pd_irq, irq}, 32'h0);
    chk({lb_sel, pp_sel}, 32'h1);
    lnk(1'b0, SZ_WORD, BAR_MEM, 8'h00, 32'h0);
    chk({rd[30:0], lerr}, swap(32'h1800_0001) << 1);
    strap <= 2'h0;
    ee_ok <= 1'b0;
    lnk(1'b0, SZ_BYTE, BAR_IO, 8'h03, 32'h0);
    chk(rd[31:24], 32'h08);
    chk({lb_sel, pp_sel}, 32'h2);
    // Word write, then pins and read-back
    lnk(1'b1, SZ_WORD, BAR_MEM, 8'h00, swap(32'hc700_00fc));
    mp2 <= 1'b1;
    uclk <= 1'b1;
    repeat (2) @(negedge clk);
    chk({eeprom_serial_clock_pin, eeprom_select_pin, eeprom_write_data_pin, lane, pme, uclk_o}, 32'h7f);
    lnk(1'b0, SZ_WORD, BAR_MEM, 8'h00, 32'h0);
    chk(rd, swap(32'h0800_00fc));
    // Byte writes through the io window, then a half write through memory
    lnk(1'b1, SZ_BYTE, BAR_IO, 8'h00, 32'h0);
    repeat (2) @(negedge clk);
    chk({eeprom_serial_clock_pin, eeprom_select_pin, eeprom_write_data_pin, pme, uclk_o, lane}, 32'h70);
    lnk(1'b1, SZ_BYTE, BAR_IO, 8'h03, 32'h0200_0000);
    chk({eeprom_serial_clock_pin, eeprom_select_pin, eeprom_write_data_pin}, 32'h2);
    lnk(1'b1, SZ_HALF, BAR_MEM, 8'h02, 32'h2800_0000);
    chk(lane, 32'h1);
    // Refused accesses change nothing
    for (int i = 0; i < 4; i++) begin
      lnk(1'b1, bad[i][1:0], bad[i][3:2], 8'h00, 32'h1800_0000);
      chk({lerr, lane}, 32'h5);
    end
    lnk(1'b0, SZ_WORD, BAR_MEM, 8'h04, 32'h0);
    chk({rd[30:0], lerr}, 32'h0);
    // Interrupt: raise, clear, mask, unmapped address
    apb(1'b0, HR_IRQ_STAT, 32'h0);
    chk(rd[1:0], 32'h3);
    apb(1'b1, HR_IRQ_MASK, 32'h1);
    @(negedge clk);
    chk(irq, 32'h1);
    apb(1'b1, HR_IRQ_STAT, 32'h3);
    @(negedge clk);
    chk(irq, 32'h0);
    apb(1'b1, HR_IRQ_MASK, 32'h0);
    lnk(1'b0, SZ_BYTE, BAR_IO, 8'h00, 32'h0);
    apb(1'b0, HR_IRQ_STAT, 32'h0);
    chk({rd[1:0], irq}, 32'h2);
    apb(1'b0, 8'h18, 32'h0);
    chk(lerr, 32'h1);
    // Power-down filter settings
    for (int i = 0; i < 4; i++) begin
      lnk(1'b1, SZ_BYTE, BAR_IO, 8'h00, {24'h0, pdb[i]});
      @(posedge clk);
      pd_req <= 1'b1;
      n = 0;
      repeat (80) begin
        @(negedge clk);
        if (pd_irq !== 1'b1) n++;
      end
      chk(n >= pdlo[i] && n <= pdhi[i], 32'h1);
      @(posedge clk);
      pd_req <= 1'b0;
      repeat (2) @(negedge clk);
      chk(pd_irq, 32'h0);
    end
    // Reload from the serial memory
    lnk(1'b1, SZ_BYTE, BAR_IO, 8'h03, 32'h2000_0000);
    chk(reload, 32'h1);
    @(posedge clk);
    ld_f <= 6'h03;
    ld_done <= 1'b1;
    @(posedge clk);
    ld_done <= 1'b0;
    repeat (3) @(negedge clk);
    chk({reload, lane, uclk_o}, 32'h3);
    final_report();
  end
endmodule
